//--- logic/cms_defs.svh
// constants for the charger mode selector
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH
`define CLK_KHZ 25000
`define BC_HOLD_MS 1250
`define QUAL_MS 1
`define HV_DONE_MS 20
`define STEP_MV 200
`define VSET_MIN 7'h12
`define VSET_5V 7'h19
`define VSET_9V 7'h2D
`define VSET_12V 7'h3C
`define VSET_20V 7'h64
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_SETPT 8'h08
`define CTRL_HV_ALLOW 0
`define CTRL_RESET 1'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- logic/cms_pkg.sv
// types shared by the charger mode selector files
package cms_pkg;
	typedef enum logic [5:0] {
		ST_BC = 6'h01,
		ST_QUAL = 6'h02,
		ST_HVWAIT = 6'h04,
		ST_FIXED = 6'h08,
		ST_CONT = 6'h10,
		ST_LEGACY = 6'h20
	} mode_t;
	typedef struct packed {
		logic dp_present;
		logic dp_high;
		logic dm_high;
		logic dm_gnd;
	} lines_t;
	typedef struct packed {
		logic above_lo;
		logic above_hi;
	} supply_t;
endpackage : cms_pkg

//--- logic/level_sync.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/100ps
module level_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [W-1:0] raw,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
		end
	end

	assign level = lvl_q;
endmodule : level_sync

//--- logic/setpoint_stepper.sv
// saturating setpoint register in 0.2 V units
`timescale 1ns/100ps
`include "cms_defs.svh"
module setpoint_stepper (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic [6:0] load_val,
	input wire logic up,
	input wire logic down,
	input wire logic [6:0] vmax,
	output logic [6:0] vset
);
	logic [6:0] v_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			v_q <= `VSET_5V;
		end else if (load) begin
			// a held code must not carry a level above a freshly lowered class limit
			v_q <= (load_val > vmax) ? vmax : load_val;
		end else if (v_q > vmax) begin
			v_q <= vmax;
		end else if (up && v_q < vmax) begin
			v_q <= v_q + 7'h01;
		end else if (down && v_q > `VSET_MIN) begin
			v_q <= v_q - 7'h01;
		end
	end

	assign vset = v_q;

	a_floor_held: assert property (@(posedge clk) disable iff (!rst_b)
		down && !load && v_q == `VSET_MIN |=> v_q == `VSET_MIN)
		else $error("setpoint stepped below floor");
endmodule : setpoint_stepper

//--- logic/charger_mode_selector.sv
// charging-port mode selector with AXI4-Lite status and control
`timescale 1ns/100ps
`include "cms_defs.svh"
module charger_mode_selector
	import cms_pkg::*;
#(
	parameter int unsigned BC_HOLD_CYC = `BC_HOLD_MS * `CLK_KHZ,
	parameter int unsigned QUAL_CYC = `QUAL_MS * `CLK_KHZ,
	parameter int unsigned HV_DONE_CYC = `HV_DONE_MS * `CLK_KHZ
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire lines_t dline_raw,
	input wire supply_t internal_supply_pin,
	input wire logic range_class_raw,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic data_line_short_switch,
	output logic dminus_pulldown_switch,
	output logic [6:0] feedback_drive_pin_level,
	output logic fb_source_en,
	output logic fb_sink_en
);
	lines_t dl;
	supply_t sup;
	logic class_b;
	logic uv_q;
	mode_t state_q;
	mode_t state_d;
	logic [31:0] tmr_q;
	logic [31:0] tmr_d;
	logic dp_hi_p_q;
	logic dm_hi_p_q;
	logic short_q;
	logic pd_q;
	logic fb_source_q;
	logic fb_sink_q;
	logic hv_allow_q;
	logic load;
	logic up;
	logic down;
	logic [6:0] load_val;
	logic [6:0] vset;
	logic [6:0] vmax;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic wr_fire;

	level_sync #(
		.W(7)
	) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.raw({dline_raw, internal_supply_pin, range_class_raw}),
		.level({dl, sup, class_b})
	);

	// latch set from reset until the supply proves itself, so power-up starts held
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			uv_q <= 1'b1;
		end else if (!sup.above_lo) begin
			uv_q <= 1'b1;
		end else if (sup.above_hi) begin
			uv_q <= 1'b0;
		end
	end

	always_comb begin
		state_d = state_q;
		tmr_d = '0;
		case (state_q)
			ST_BC: begin
				tmr_d = tmr_q + 32'h1;
				if (tmr_q >= BC_HOLD_CYC - 1) begin
					state_d = ST_QUAL;
					tmr_d = '0;
				end
			end
			ST_QUAL: begin
				// a device that never releases D- simply stays here at 5 V
				if (dl.dm_gnd) begin
					tmr_d = tmr_q + 32'h1;
				end
				if (dl.dm_gnd && tmr_q >= QUAL_CYC - 1) begin
					state_d = hv_allow_q ? ST_HVWAIT : ST_LEGACY;
					tmr_d = '0;
				end
			end
			ST_HVWAIT: begin
				tmr_d = tmr_q + 32'h1;
				if (tmr_q >= HV_DONE_CYC - 1) begin
					state_d = ST_FIXED;
					tmr_d = '0;
				end
			end
			ST_FIXED: begin
				if (!dl.dp_high && dl.dm_high) begin
					state_d = ST_CONT;
				end
			end
			ST_CONT: begin
				// pulses never touch D- ground, so only a true 5 V request leaves
				if (!dl.dp_high && dl.dm_gnd) begin
					state_d = ST_FIXED;
				end
			end
			default: begin
				state_d = state_q;
			end
		endcase
		if (uv_q || !dl.dp_present) begin
			state_d = ST_BC;
			tmr_d = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_BC;
			tmr_q <= '0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			short_q <= 1'b1;
			pd_q <= 1'b0;
		end else begin
			short_q <= state_d == ST_BC || state_d == ST_QUAL || state_d == ST_LEGACY;
			pd_q <= state_d == ST_FIXED || state_d == ST_CONT;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dp_hi_p_q <= 1'b0;
			dm_hi_p_q <= 1'b0;
		end else begin
			dp_hi_p_q <= dl.dp_high;
			dm_hi_p_q <= dl.dm_high;
		end
	end

	assign vmax = class_b ? `VSET_20V : `VSET_12V;

	always_comb begin
		load = 1'b1;
		load_val = `VSET_5V;
		up = 1'b0;
		down = 1'b0;
		case (state_q)
			ST_FIXED: begin
				load_val = vset;
				if (dl.dm_gnd) begin
					load_val = `VSET_5V;
				end else if (!dl.dm_high) begin
					load_val = dl.dp_high ? `VSET_9V : `VSET_12V;
				end else if (dl.dp_high && class_b) begin
					load_val = `VSET_20V;
				end
			end
			ST_CONT: begin
				load = 1'b0;
				up = dp_hi_p_q && !dl.dp_high && dl.dm_high;
				// a d+ fall in the same cycle is an up step, never a down as well
				down = !dm_hi_p_q && dl.dm_high && !dl.dp_high && !dp_hi_p_q;
			end
			default: begin
				load_val = `VSET_5V;
			end
		endcase
		if (uv_q || !dl.dp_present) begin
			load = 1'b1;
			load_val = `VSET_5V;
			up = 1'b0;
			down = 1'b0;
		end
	end

	setpoint_stepper u_step (
		.clk(clk),
		.rst_b(rst_b),
		.load(load),
		.load_val(load_val),
		.up(up),
		.down(down),
		.vmax(vmax),
		.vset(vset)
	);

	// drive follows the setpoint one cycle later
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fb_source_q <= 1'b0;
			fb_sink_q <= 1'b0;
		end else begin
			fb_source_q <= vset < `VSET_5V;
			fb_sink_q <= vset > `VSET_5V;
		end
	end

	assign wr_fire = !awready_q && !wready_q && !bvalid_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			awready_q <= 1'b1;
			aw_addr_q <= '0;
		end else if (awvalid && awready_q) begin
			awready_q <= 1'b0;
			aw_addr_q <= awaddr;
		end else if (wr_fire) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wready_q <= 1'b1;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (wvalid && wready_q) begin
			wready_q <= 1'b0;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (wr_fire) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			if (aw_addr_q == `ADDR_CTRL || aw_addr_q == `ADDR_STATUS) begin
				bresp_q <= `RESP_OKAY;
			end else if (aw_addr_q == `ADDR_SETPT) begin
				bresp_q <= `RESP_OKAY;
			end else begin
				bresp_q <= `RESP_SLVERR;
			end
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hv_allow_q <= `CTRL_RESET;
		end else if (wr_fire && aw_addr_q == `ADDR_CTRL && w_strb_q[0]) begin
			hv_allow_q <= w_data_q[`CTRL_HV_ALLOW];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `RESP_OKAY;
		end else if (arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= `RESP_OKAY;
			if (araddr == `ADDR_CTRL) begin
				rdata_q <= {31'h0, hv_allow_q};
			end else if (araddr == `ADDR_STATUS) begin
				rdata_q <= {20'h0, uv_q, class_b, pd_q, short_q, 2'h0, state_q};
			end else if (araddr == `ADDR_SETPT) begin
				rdata_q <= {22'h0, fb_sink_q, fb_source_q, 1'h0, vset};
			end else begin
				rdata_q <= '0;
				rresp_q <= `RESP_SLVERR;
			end
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign data_line_short_switch = short_q;
	assign dminus_pulldown_switch = pd_q;
	assign feedback_drive_pin_level = vset;
	assign fb_source_en = fb_source_q;
	assign fb_sink_en = fb_sink_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_fixed_9v;
		state_q == ST_FIXED && dl.dp_present && !uv_q && dl.dp_high && !dl.dm_high && !dl.dm_gnd;
	endsequence

	sequence s_unplug;
		!dl.dp_present;
	endsequence

	sequence s_step_up;
		state_q == ST_CONT && dl.dp_present && !uv_q && up && vset < vmax;
	endsequence

	a_release_short: assert property ($fell(uv_q) |-> short_q && !pd_q)
		else $error("short not closed after supply reset");

	a_short_opens_hv: assert property ($fell(short_q) |-> state_q == ST_HVWAIT && hv_allow_q)
		else $error("short opened without qualification");

	a_pulldown_after_hv: assert property ($rose(pd_q) |-> $past(state_q) == ST_HVWAIT)
		else $error("pull-down closed before handshake done");

	a_code_nine_volt: assert property (s_fixed_9v |=> vset == `VSET_9V)
		else $error("9 V code not applied");

	a_cont_entry: assert property (state_q == ST_FIXED && dl.dp_present && !uv_q
		&& !dl.dp_high && dl.dm_high |=> state_q == ST_CONT)
		else $error("continuous mode not entered");

	a_class_limit: assert property (!class_b && !$past(class_b) && !$past(class_b, 2)
		|-> vset <= `VSET_12V)
		else $error("setpoint above first class maximum");

	a_unplug_default: assert property (s_unplug |=> short_q && !pd_q && vset == `VSET_5V)
		else $error("default mode not restored on unplug");

	a_fb_off_default: assert property (vset == `VSET_5V |=> !fb_source_q && !fb_sink_q)
		else $error("feedback drive active at 5 V");

	a_legacy_five: assert property (state_q == ST_LEGACY
		|-> vset == `VSET_5V && short_q && !pd_q)
		else $error("legacy device left 5 V");

	a_uv_hold: assert property (uv_q && !sup.above_hi |=> uv_q && state_q == ST_BC)
		else $error("released before supply recovered");

	a_step_up: assert property (s_step_up |=> vset == $past(vset) + 7'h01)
		else $error("step up not applied");
endmodule : charger_mode_selector

//--- sim/pd_model.sv
// powered device model driving the data-line comparator levels
`timescale 1ns/100ps
module pd_model
	import cms_pkg::*;
(
	input wire logic clk,
	input wire logic plugged,
	input wire logic [2:0] code,
	input wire logic short_on,
	output lines_t lines
);
	logic dp_hi;
	logic dm_hi;
	// code 0 0.6/gnd, 1 0.6/0.6, 2 3.3/0.6, 3 3.3/3.3, 4 0.6/3.3
	assign dp_hi = code == 3'h2 || code == 3'h3;
	assign dm_hi = code == 3'h3 || code == 3'h4;
	initial lines = 4'h1;
	// closed short ties d- to d+, so only a grounded d- overrides it
	always @(posedge clk) begin
		if (!plugged)
			lines <= 4'h1;
		else if (short_on && code != 3'h0)
			lines <= {1'b1, dp_hi, dp_hi, 1'b0};
		else
			lines <= {1'b1, dp_hi, dm_hi, code == 3'h0};
	end
endmodule : pd_model

//--- sim/charger_mode_selector_tb.sv
// self-checking bench for the charger mode selector
`timescale 1ns/100ps
`include "cms_defs.svh"
module charger_mode_selector_tb
	import cms_pkg::*;
;
	logic clk = 0, rst_b = 0, cls = 0, plugged = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, shrt, pdn, src, snk;
	logic [2:0] code = 3'h1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rdat, rnd = 32'h2736;
	logic [1:0] bresp, rresp, resp;
	logic [6:0] lvl;
	lines_t lines;
	supply_t sup = 2'h3;
	int fail_count = 0, tests_run = 0, cyc = 0, ex;
	localparam logic [2:0] TCODE [7] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h3, 3'h3, 3'h0};
	localparam logic TCLS [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	localparam logic [6:0] TEXP [7] = '{`VSET_12V, `VSET_9V, `VSET_9V, `VSET_5V, `VSET_20V,
		`VSET_12V, `VSET_5V};
	always #20 clk = ~clk;
	charger_mode_selector #(.BC_HOLD_CYC(20), .QUAL_CYC(5), .HV_DONE_CYC(10)) dut_u (
		.clk(clk), .rst_b(rst_b), .dline_raw(lines), .internal_supply_pin(sup),
		.range_class_raw(cls), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.data_line_short_switch(shrt), .dminus_pulldown_switch(pdn),
		.feedback_drive_pin_level(lvl), .fb_source_en(src), .fb_sink_en(snk));
	pd_model pd_u (.clk(clk), .plugged(plugged), .code(code), .short_on(shrt), .lines(lines));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	task automatic bad(input string m);
		fail_count++;
		$display("MISMATCH t=%0t %s", $time, m);
	endtask : bad
	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
			bad($sformatf("bus %h exp %h", got, exp));
	endtask : chk_bus
	// the feedback enables follow from the setpoint relative to 5 v
	task automatic chk_pins(input logic s, input logic p, input logic [6:0] v);
		tests_run++;
		if ({shrt, pdn, lvl, src, snk} !== {s, p, v, v < `VSET_5V, v > `VSET_5V})
			bad($sformatf("pins %b%b %h%b%b exp %b%b %h", shrt, pdn, lvl, src, snk, s, p, v));
	endtask : chk_pins
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic put(input logic [2:0] c, input int n);
		@(posedge clk);
		plugged <= 1'b1;
		code <= c;
		tick(n);
	endtask : put
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rdat = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic unplug;
		@(posedge clk);
		plugged <= 1'b0;
		tick(12);
	endtask : unplug
	// ceiling well above the fewer than two thousand cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad("timeout");
			report_and_stop;
		end
	end
	initial begin
		int k;
		tick(20);
		rst_b <= 1'b1;
		tick(2);
		chk_pins(1'b1, 1'b0, `VSET_5V);
		rd(`ADDR_CTRL);
		chk_bus(rdat, 32'h1);
		rd(8'h0C);
		chk_bus({rdat[31:2], resp}, {30'h0, `RESP_SLVERR});
		rnd = xs(rnd);
		wr(8'h0C, rnd);
		chk_bus(32'(resp), 32'(`RESP_SLVERR));
		$display("test reset and bus done");
		put(3'h1, 30);
		put(3'h0, 14);
		chk_pins(1'b0, 1'b0, `VSET_5V);
		tick(16);
		chk_pins(1'b0, 1'b1, `VSET_5V);
		$display("test handshake done");
		for (int i = 0; i < 7; i++) begin
			cls <= TCLS[i];
			put(TCODE[i], 12);
			chk_pins(1'b0, 1'b1, TEXP[i]);
		end
		$display("test fixed codes done");
		cls <= 1'b0;
		put(3'h4, 12);
		repeat (10) begin
			put(3'h1, 8);
			put(3'h4, 8);
		end
		chk_pins(1'b0, 1'b1, `VSET_MIN);
		repeat (45) begin
			put(3'h3, 8);
			put(3'h4, 8);
		end
		chk_pins(1'b0, 1'b1, `VSET_12V);
		rnd = xs(rnd);
		k = int'(rnd[2:0]) + 1;
		ex = int'(`VSET_12V) - k;
		repeat (k) begin
			put(3'h1, 8);
			put(3'h4, 8);
		end
		chk_pins(1'b0, 1'b1, 7'(ex));
		put(3'h0, 12);
		chk_pins(1'b0, 1'b1, `VSET_5V);
		$display("test continuous done");
		unplug();
		chk_pins(1'b1, 1'b0, `VSET_5V);
		rnd = xs(rnd);
		wr(`ADDR_CTRL, {rnd[31:1], 1'b0});
		chk_bus(32'(resp), 32'(`RESP_OKAY));
		put(3'h1, 30);
		put(3'h0, 14);
		put(3'h2, 12);
		chk_pins(1'b1, 1'b0, `VSET_5V);
		rd(`ADDR_STATUS);
		chk_bus(32'({rdat[8], rdat[5:0]}), 32'({1'b1, ST_LEGACY}));
		$display("test legacy done");
		wr(`ADDR_CTRL, 32'h1);
		unplug();
		put(3'h1, 30);
		put(3'h0, 30);
		put(3'h2, 12);
		chk_pins(1'b0, 1'b1, `VSET_9V);
		rd(`ADDR_SETPT);
		chk_bus(rdat, {22'h0, 1'b1, 1'b0, 1'b0, `VSET_9V});
		@(posedge clk);
		sup <= 2'h0;
		tick(10);
		chk_pins(1'b1, 1'b0, `VSET_5V);
		@(posedge clk);
		sup <= 2'h2;
		tick(40);
		chk_pins(1'b1, 1'b0, `VSET_5V);
		rd(`ADDR_STATUS);
		chk_bus(32'(rdat[11]), 32'h1);
		@(posedge clk);
		sup <= 2'h3;
		tick(10);
		rd(`ADDR_STATUS);
		chk_bus(32'(rdat[11]), 32'h0);
		$display("test undervoltage done");
		report_and_stop;
	end
endmodule : charger_mode_selector_tb
